// file: pkg/er_pkg.sv
// Purpose: Shared constants of the event router
// Assumes: APB slave with 32-bit data and 12-bit byte addresses
// Notes: Offsets are byte addresses, one aligned word each

package er_pkg;

  // ****************************************
  // Sizes
  // ****************************************
  localparam int ER_NOUT = 5;
  localparam int ER_NIRQ = 4;
  localparam int ER_WAKE = 4;
  localparam int ER_AW = 12;

  // ****************************************
  // Register offsets
  // ****************************************
  localparam logic [11:0] ER_POLARITY = 12'h000;
  localparam logic [11:0] ER_MODE = 12'h004;
  localparam logic [11:0] ER_GLOBAL_EN = 12'h008;
  localparam logic [11:0] ER_LATCH_CLR = 12'h00C;
  localparam logic [11:0] ER_INPUT_STATE = 12'h010;
  localparam logic [11:0] ER_LATCH_STATE = 12'h014;
  localparam logic [11:0] ER_OUT_MASK = 12'h020;
  localparam logic [11:0] ER_OUT_STATUS = 12'h040;
  localparam logic [11:0] ER_IRQ_STATUS = 12'h060;
  localparam logic [11:0] ER_IRQ_CLR = 12'h064;
  localparam logic [11:0] ER_IRQ_ENABLE = 12'h068;
  localparam logic [11:0] ER_OUT_STRIDE = 12'h004;

  // ****************************************
  // Reset values
  // ****************************************
  localparam logic [31:0] ER_RST_POL = 32'hFFFFFFFF;
  localparam logic [31:0] ER_RST_MODE = 32'h00000000;
  localparam logic [31:0] ER_RST_GEN = 32'h00000000;
  localparam logic [31:0] ER_RST_OMASK = 32'h00000000;
  localparam logic [4:0] ER_RST_IRQEN = 5'h00;

endpackage

// file: rtl/er_event_router.sv
// Purpose: Event router, routes pin and internal events to four
//   interrupt lines and one wake-up line, with an APB register file
// Assumes: clk runs whenever software or an event must be seen
// Notes: Inputs are synchronised; a pin change reaches the outputs
//   after three edges (direct) or four edges (latched)

`timescale 1ns/100ps

module er_event_router
  import er_pkg::*;
#(
  parameter int NUM_IN = 32
) (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // APB slave
  input wire logic [ER_AW-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Event inputs, pins and internal signals
  input wire logic [NUM_IN-1:0] evtIn,
  // Routed outputs
  output logic [ER_NIRQ-1:0] eventIrq,
  output logic wakeUp,
  output logic irq
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    logic [NUM_IN-1:0] sync1;
    logic [NUM_IN-1:0] sync2;
    logic [NUM_IN-1:0] prev;
    logic [NUM_IN-1:0] latch;
    logic [NUM_IN-1:0] pol;
    logic [NUM_IN-1:0] mode;
    logic [NUM_IN-1:0] gEn;
    logic [ER_NOUT-1:0][NUM_IN-1:0] oMask;
    logic [ER_NOUT-1:0][NUM_IN-1:0] contrib;
    logic [ER_NOUT-1:0] outLvl;
    logic [ER_NOUT-1:0] irqSts;
    logic [ER_NOUT-1:0] irqEn;
    logic [31:0] rdata;
  } er_state_t;

  er_state_t st;
  er_state_t next_st;

  logic [NUM_IN-1:0] active;
  logic [NUM_IN-1:0] rise;
  logic [NUM_IN-1:0] evt;
  logic [NUM_IN-1:0] latClr;
  logic [ER_NOUT-1:0] outRise;
  logic [ER_NOUT-1:0] irqClr;
  logic apbWr;
  logic apbSetup;
  logic mapped;
  logic [31:0] rdMux;

  // ****************************************
  // APB decode
  // ****************************************
  // Zero wait states: every access completes in its first access cycle
  assign pready = 1'b1;
  assign apbWr = psel & penable & pwrite;
  assign apbSetup = psel & ~penable;
  assign pslverr = psel & penable & ~mapped;
  assign prdata = st.rdata;

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    next_st = st;
    mapped = 1'b0;
    rdMux = 32'h00000000;
    // Second stage only reads the first; logic starts after stage two
    next_st.sync1 = evtIn;
    next_st.sync2 = st.sync1;
    active = ~(st.sync2 ^ st.pol);
    rise = active & ~st.prev;
    next_st.prev = active;
    latClr = '0;
    if (apbWr && paddr == ER_LATCH_CLR) begin
      latClr = pwdata[NUM_IN-1:0];
    end
    // A new edge in the clearing cycle wins over the clear
    next_st.latch = (st.latch & ~latClr) | (rise & st.mode);
    evt = (st.mode & st.latch) | (~st.mode & active);
    for (int k = 0; k < ER_NOUT; k++) begin
      next_st.contrib[k] = evt & st.gEn & st.oMask[k];
      next_st.outLvl[k] = |next_st.contrib[k];
    end
    outRise = next_st.outLvl & ~st.outLvl;
    irqClr = '0;
    if (apbWr && paddr == ER_IRQ_CLR) begin
      irqClr = pwdata[ER_NOUT-1:0];
    end
    next_st.irqSts = (st.irqSts & ~irqClr) | outRise;
    // Register writes
    if (apbWr) begin
      case (paddr)
        ER_POLARITY: begin
          next_st.pol = pwdata[NUM_IN-1:0];
        end
        ER_MODE: begin
          next_st.mode = pwdata[NUM_IN-1:0];
        end
        ER_GLOBAL_EN: begin
          next_st.gEn = pwdata[NUM_IN-1:0];
        end
        ER_IRQ_ENABLE: begin
          next_st.irqEn = pwdata[ER_NOUT-1:0];
        end
        default: begin
          for (int k = 0; k < ER_NOUT; k++) begin
            if (paddr == ER_OUT_MASK + ER_OUT_STRIDE * 12'(k)) begin
              next_st.oMask[k] = pwdata[NUM_IN-1:0];
            end
          end
        end
      endcase
    end
    // Read decode, also used for the error answer
    case (paddr)
      ER_POLARITY: begin
        mapped = 1'b1;
        rdMux = 32'(st.pol);
      end
      ER_MODE: begin
        mapped = 1'b1;
        rdMux = 32'(st.mode);
      end
      ER_GLOBAL_EN: begin
        mapped = 1'b1;
        rdMux = 32'(st.gEn);
      end
      ER_LATCH_CLR: begin
        mapped = 1'b1;
      end
      ER_INPUT_STATE: begin
        mapped = 1'b1;
        rdMux = 32'(active);
      end
      ER_LATCH_STATE: begin
        mapped = 1'b1;
        rdMux = 32'(st.latch);
      end
      ER_IRQ_STATUS: begin
        mapped = 1'b1;
        rdMux = 32'(st.irqSts);
      end
      ER_IRQ_CLR: begin
        mapped = 1'b1;
      end
      ER_IRQ_ENABLE: begin
        mapped = 1'b1;
        rdMux = 32'(st.irqEn);
      end
      default: begin
        for (int k = 0; k < ER_NOUT; k++) begin
          if (paddr == ER_OUT_MASK + ER_OUT_STRIDE * 12'(k)) begin
            mapped = 1'b1;
            rdMux = 32'(st.oMask[k]);
          end
          if (paddr == ER_OUT_STATUS + ER_OUT_STRIDE * 12'(k)) begin
            mapped = 1'b1;
            rdMux = 32'(st.contrib[k]);
          end
        end
      end
    endcase
    // Read data is caught in the setup cycle, stable through access
    if (apbSetup) begin
      next_st.rdata = rdMux;
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      st <= '0;
      st.pol <= ER_RST_POL[NUM_IN-1:0];
      st.mode <= ER_RST_MODE[NUM_IN-1:0];
      st.gEn <= ER_RST_GEN[NUM_IN-1:0];
      st.oMask <= {ER_NOUT{ER_RST_OMASK[NUM_IN-1:0]}};
      st.irqEn <= ER_RST_IRQEN;
    end else begin
      st <= next_st;
    end
  end

  // ****************************************
  // Outputs
  // ****************************************
  // Only the block clock must run; a bus or core clock may be stopped
  assign eventIrq = st.outLvl[ER_NIRQ-1:0];
  // Clock unit reacts to this level to restart module clocks
  assign wakeUp = st.outLvl[ER_WAKE];
  assign irq = |(st.irqSts & st.irqEn);

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Watched inputs are the ones the bench drives: 3 and 31 direct, 5 latched
  a_latch_hold: assert property (
    (st.latch[5] && !latClr[5]) |=> st.latch[5]
  ) else $error("latched event lost without a clear");

  a_direct_drop: assert property (
    (!st.mode[3] && !active[3]) |=> !st.contrib[1][3]
  ) else $error("direct event outlived its input");

  a_global_block: assert property (
    !st.gEn[3] |=> (!st.contrib[1][3] && !st.contrib[4][3])
  ) else $error("globally disabled input reached an output");

  a_edge_latch: assert property (
    (rise[5] && st.mode[5]) |=> st.latch[5] ##1 (st.contrib[4][5] ||
      !$past(st.gEn[5]) || !$past(st.oMask[4][5]))
  ) else $error("latched edge did not reach the wake output");

  a_latch_clear: assert property (
    (latClr[5] && !(rise[5] && st.mode[5])) |=> !st.latch[5]
  ) else $error("latch clear did not take");

  a_wake_route: assert property (
    $rose(wakeUp) |-> $past((st.gEn & st.oMask[ER_WAKE]) != '0)
  ) else $error("wake-up rose with no routed input");

  a_direct_rise: assert property (
    (!st.mode[3] && active[3] && st.gEn[3] && st.oMask[1][3]) |=>
      eventIrq[1]
  ) else $error("direct event did not reach output one");

  a_out_route: assert property (
    $rose(eventIrq[0]) |-> $past((st.gEn & st.oMask[0]) != '0)
  ) else $error("output zero rose with no routed input");

  a_irq_set: assert property (
    $rose(st.outLvl[2]) |-> st.irqSts[2]
  ) else $error("output two rise not recorded");

  a_irq_level: assert property (
    (st.irqSts[1] && st.irqEn[1]) |-> irq
  ) else $error("enabled status bit left irq low");

  a_irq_clear: assert property (
    (apbWr && paddr == ER_IRQ_CLR && pwdata[1] && !outRise[1]) |=>
      !st.irqSts[1]
  ) else $error("status clear did not take");

  a_direct_nolatch: assert property (
    (!st.mode[3] && !st.latch[3]) |=> !st.latch[3]
  ) else $error("direct input set a latch");

  a_pol_low: assert property (
    (!st.pol[3] && !st.sync2[3]) |-> active[3]
  ) else $error("low polarity input not seen active");

  a_pol_high: assert property (
    (st.pol[3] && st.sync2[3]) |-> active[3]
  ) else $error("high polarity input not seen active");

  a_global_pass: assert property (
    (active[31] && !st.mode[31] && st.gEn[31] && st.oMask[2][31]) |=>
      st.contrib[2][31]
  ) else $error("enabled input did not reach output two");

  a_mask_route: assert property (
    !st.oMask[0][31] |=> !st.contrib[0][31]
  ) else $error("masked input reached output zero");

  a_sync_delay: assert property (
    st.sync2 == $past(evtIn, 2)
  ) else $error("input synchroniser delay is not two edges");

  // ****************************************
  // Checks on the register bus, status and pin path
  // ****************************************
  // Write effects one edge after the access edge that takes them
  a_pol_write: assert property (
    (apbWr && paddr == ER_POLARITY) |=> st.pol == $past(pwdata[NUM_IN-1:0])
  ) else $error("polarity write did not land");

  a_mode_write: assert property (
    (apbWr && paddr == ER_MODE) |=> st.mode == $past(pwdata[NUM_IN-1:0])
  ) else $error("mode write did not land");

  a_enable_write: assert property (
    (apbWr && paddr == ER_GLOBAL_EN) |=> st.gEn == $past(pwdata[NUM_IN-1:0])
  ) else $error("global enable write did not land");

  a_mask_write: assert property (
    (apbWr && paddr == ER_OUT_MASK + ER_OUT_STRIDE) |=>
      st.oMask[1] == $past(pwdata[NUM_IN-1:0])
  ) else $error("output one mask write did not land");

  // Read data is caught at the setup edge, so it shows the state there
  a_status_read: assert property (
    (apbSetup && paddr == ER_OUT_STATUS + ER_OUT_STRIDE) |=>
      prdata == 32'($past(st.contrib[1]))
  ) else $error("output one status read is wrong");

  a_latch_read: assert property (
    (apbSetup && paddr == ER_LATCH_STATE) |=>
      prdata == 32'($past(st.latch))
  ) else $error("latch state read is wrong");

  a_irq_sticky: assert property (
    $rose(eventIrq[0]) |=> st.irqSts[0]
  ) else $error("output rise not recorded in status");

  a_pin_route: assert property (
    ($rose(evtIn[3]) && st.pol[3] && !st.mode[3] && st.gEn[3] &&
      st.oMask[1][3]) ##1 (evtIn[3] && st.pol[3] && !st.mode[3] &&
      st.gEn[3] && st.oMask[1][3]) [*2] |=> eventIrq[1]
  ) else $error("pin event failed to reach output one");

endmodule

// file: verification/er_far_side.sv
// Purpose: Far side model, interrupt collector and clock unit
// Assumes: Block clock keeps running in suspend
// Notes: Clocks stay on once woken; the bench never turns them off

`timescale 1ns/100ps

module er_far_side (
  // Clock and reset
  input wire logic clk,
  input wire logic sys_rst,
  // Routed lines
  input wire logic [3:0] eventIrq,
  input wire logic wakeUp,
  // Observed effects
  output logic clkOn,
  output logic [3:0] irqSeen
);
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      clkOn <= 1'b0;
      irqSeen <= 4'h0;
    end else begin
      if (wakeUp) begin
        clkOn <= 1'b1;
      end
      irqSeen <= irqSeen | eventIrq;
    end
  end
endmodule

// file: verification/event_router_tb.sv
// Purpose: Self-checking bench of the event router
// Assumes: Zero-wait APB slave, fixed event latency of a few edges
// Notes: Settling waits are fixed because the latency is fixed

`timescale 1ns/100ps

module event_router_tb;
  import er_pkg::*;
  logic clk, sys_rst, psel, penable, pwrite, pready, pslverr;
  logic wakeUp, irq, clkOn, slvErr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd, evtIn;
  logic [3:0] eventIrq, irqSeen;
  int errCount, nChecks;

  er_event_router dut_u (.clk(clk), .sys_rst(sys_rst), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .evtIn(evtIn),
    .eventIrq(eventIrq), .wakeUp(wakeUp), .irq(irq));
  er_far_side far_u (.clk(clk), .sys_rst(sys_rst), .eventIrq(eventIrq),
    .wakeUp(wakeUp), .clkOn(clkOn), .irqSeen(irqSeen));

  // ****************************************
  // Tasks
  // ****************************************
  task print_verdict;
    if (errCount == 0 && nChecks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    nChecks++;
    if (got !== exp) begin
      errCount++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic w, input logic [11:0] a,
                     input logic [31:0] d);
    int i;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge clk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (i >= 20) begin
      errCount++;
      print_verdict;
    end
    rd = prdata;
    slvErr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task settle;
    repeat (6) @(posedge clk);
  endtask

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Hang guard, far above the length of the sequence
  initial begin
    repeat (5000) @(posedge clk);
    errCount++;
    print_verdict;
  end

  // ****************************************
  // Sequence
  // ****************************************
  initial begin
    sys_rst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    evtIn = 32'h0;
    errCount = 0;
    nChecks = 0;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    apb(1'b0, ER_POLARITY, 32'h0);
    chk(rd, ER_RST_POL);
    apb(1'b0, ER_MODE, 32'h0);
    chk(rd, ER_RST_MODE);
    apb(1'b0, ER_OUT_MASK + ER_OUT_STRIDE, 32'h0);
    chk(rd, ER_RST_OMASK);
    apb(1'b1, ER_GLOBAL_EN, 32'h80000008);
    apb(1'b1, ER_OUT_MASK + ER_OUT_STRIDE, 32'h00000008);
    apb(1'b1, ER_IRQ_ENABLE, 32'h00000002);
    evtIn[3] <= 1'b1;
    settle;
    chk(32'(eventIrq), 32'h2);
    chk(32'(irq), 32'h1);
    apb(1'b0, ER_OUT_STATUS + ER_OUT_STRIDE, 32'h0);
    chk(rd, 32'h8);
    evtIn[3] <= 1'b0;
    settle;
    chk(32'(eventIrq), 32'h0);
    apb(1'b1, ER_IRQ_CLR, 32'h2);
    chk(32'(irq), 32'h0);
    apb(1'b1, ER_POLARITY, 32'hFFFFFFF7);
    settle;
    chk(32'(eventIrq), 32'h2);
    apb(1'b0, ER_INPUT_STATE, 32'h0);
    chk(rd, 32'h8);
    apb(1'b0, ER_IRQ_STATUS, 32'h0);
    chk(rd, 32'h2);
    chk(32'(pready), 32'h1);
    apb(1'b1, ER_POLARITY, 32'hFFFFFFFF);
    apb(1'b1, ER_GLOBAL_EN, 32'h80000000);
    evtIn[3] <= 1'b1;
    settle;
    chk(32'(eventIrq), 32'h0);
    evtIn[3] <= 1'b0;
    apb(1'b1, ER_OUT_MASK, 32'h80000000);
    apb(1'b1, ER_OUT_MASK + 12'h008, 32'h80000000);
    evtIn[31] <= 1'b1;
    settle;
    chk(32'(eventIrq), 32'h5);
    chk(32'(wakeUp), 32'h0);
    evtIn[31] <= 1'b0;
    apb(1'b1, ER_MODE, 32'h00000020);
    apb(1'b1, ER_GLOBAL_EN, 32'h00000020);
    apb(1'b1, ER_OUT_MASK + 12'h010, 32'h00000020);
    evtIn[5] <= 1'b1;
    repeat (3) @(posedge clk);
    evtIn[5] <= 1'b0;
    settle;
    chk(32'(wakeUp), 32'h1);
    chk(32'(clkOn), 32'h1);
    apb(1'b0, ER_LATCH_STATE, 32'h0);
    chk(rd, 32'h20);
    apb(1'b1, ER_LATCH_CLR, 32'h20);
    settle;
    chk(32'(wakeUp), 32'h0);
    apb(1'b0, ER_OUT_STATUS + 12'h010, 32'h0);
    chk(rd, 32'h0);
    chk(32'(irqSeen), 32'h7);
    apb(1'b0, 12'hFFC, 32'h0);
    chk(32'(slvErr), 32'h1);
    chk(rd, 32'h0);
    print_verdict;
  end
endmodule
